// ---- rtl/pcf_io_top.sv ----
// connector and flag block of a small plc: input filters, i/o mapping, flags, budget
// Operation
// R1 - mains variant: inputs one to eight accept rise after 25 ms, fall after 20 ms
// R2 - other variants: every input accepts a new level after 5 ms stable
// R3 - slave mode: 5 ms on-delay, accepted high held for 100 ms
// R4 - terminals 1,2,7,8 read digitally and as analog three, four, one, two
// R5 - configuration enables two or all four on-board analog inputs
// R6 - expansion analog channels numbered after the existing analog inputs
// R7 - digital inputs and outputs numbered base unit first, then modules in order
// R8 - 64 blank outputs, write only, never read back
// R9 - eight analog outputs, fed only from analog sources
// R10 - 64 digital and 64 analog flags, each outputs the value written to it; backlight flags 24, 25, 27-30 are set from mode and error instead
// R11 - flag outputs show previous cycle's value, stable within a cycle
// R12 - startup flag high during first cycle, cleared at its end, then ordinary
// R13 - backlight flags: white run, amber program/parameter, red diagnostic error; panel amber is also lit in setup mode
// R14 - charset flag selects message set; unused flag means preconfigured set
// R15 - network reads and writes flags; charset flag works only if in program
// R16 - shift-register bits are read only for the bus
// R17 - up to four cursor keys as inputs, panel keys same as base keys
// R18 - program capped at 8500 bytes, 400 blocks, 250 retentive bytes
// R19 - a block is refused when bytes, block count or retentive room run out
// R20 - bytes, blocks and retentive bytes summed apart; retentive only when enabled
// R21 - each input filter counts milliseconds, cleared while raw equals accepted level
//
// Added by the designer: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ns
`include "pcf_defines.svh"
module pcf_io_top #(
    parameter int NUM_DI = 24,
    parameter int NUM_DQ = 20,
    parameter int NUM_EXP_AI = 4,
    parameter int CYC_PER_MS = `PCF_CYC_PER_MS,
    parameter int MAX_BYTES = `PCF_MAX_BYTES,
    parameter int MAX_BLOCKS = `PCF_MAX_BLOCKS,
    parameter int MAX_REM = `PCF_MAX_REM
) (
    input logic aclk,
    input logic aresetn,
    input pcf_pkg::pcf_axi_req_t axi_req,
    output pcf_pkg::pcf_axi_rsp_t axi_rsp,
    input logic [NUM_DI-1:0] din_raw,
    input logic [3:0][15:0] term_ana,
    input logic [NUM_EXP_AI-1:0][15:0] exp_ana,
    input logic [3:0] keys_base,
    input logic [3:0] keys_panel,
    input logic [31:0] shift_bits,
    input pcf_pkg::pcf_mode_t base_mode,
    input pcf_pkg::pcf_mode_t panel_mode,
    input logic base_diag_err,
    input logic panel_diag_err,
    output logic [NUM_DI-1:0] din_filt,
    output logic [NUM_DQ-1:0] dq_out,
    output logic [7:0][15:0] aq_out,
    output logic [63:0] flag_out,
    output pcf_pkg::pcf_backlight_t base_backlight,
    output pcf_pkg::pcf_backlight_t panel_backlight,
    output logic charset_sel,
    output logic first_cycle
);
    import pcf_pkg::*;

    localparam int MS_W = 17;

    initial begin
        if (NUM_DI < `PCF_MAINS_INPUTS || NUM_DI > 32 || NUM_DQ < 1 || NUM_DQ > 32 ||
            NUM_EXP_AI < 1 || NUM_EXP_AI > 4 || CYC_PER_MS < 1 || CYC_PER_MS > 2**MS_W ||
            MAX_BYTES > 16383 || MAX_BLOCKS > 511 || MAX_REM > 255) begin
            $error("pcf_io_top: parameter out of range");
        end
    end

    typedef struct packed {
        logic [4:0] ctrl;
        logic [MS_W-1:0] ms_cnt;
        logic ms_tick;
        logic [NUM_DI-1:0] din_s;
        logic [NUM_DI-1:0] din_acc;
        logic [NUM_DI-1:0][6:0] flt_cnt;
        logic [3:0] keys;
        logic [NUM_DQ-1:0] dq;
        logic [7:0][15:0] aq;
        logic [63:0] flag_nxt;
        logic [63:0] flag_vis;
        logic [63:0] af_sel;
        logic [63:0] af_dirty;
        logic [63:0] af_valid;
        logic first;
        logic [13:0] mem_bytes;
        logic [8:0] mem_blocks;
        logic [7:0] mem_rem;
        logic mem_refused;
        pcf_backlight_t bl_base;
        pcf_backlight_t bl_panel;
        logic charset;
        logic awready;
        logic [11:0] aw_addr;
        logic wready;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        pcf_rd_st_t rd_st;
        logic arready;
        logic [11:0] ar_addr;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic rvalid;
    } pcf_st_t;

    pcf_st_t st_ff;
    pcf_st_t nxt_st;
    logic ram_we;
    logic [6:0] ram_waddr;
    logic [15:0] ram_wdata;
    logic [6:0] ram_raddr;
    logic [15:0] ram_rdata;

    // ----------------------------------------------------------------
    // decode helpers
    // ----------------------------------------------------------------
    function automatic logic is_aflag(input logic [11:0] a);
        return a[11:8] == `PCF_OFS_AFLAG >> 8;
    endfunction

    function automatic logic [5:0] aflag_idx(input logic [11:0] a);
        return a[7:2];
    endfunction

    function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] val,
                                           input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[b*8 +: 8] = val[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // ----------------------------------------------------------------
    // analog channel map
    // ----------------------------------------------------------------
    logic [7:0][15:0] ain_map;
    always_comb begin
        int nb;
        nb = st_ff.ctrl[`PCF_CTRL_FOUR_AI] ? 4 : 2; // [R5]
        for (int k = 0; k < 8; k++) begin
            ain_map[k] = 16'h0000;
            if (k < 2) begin
                ain_map[k] = term_ana[k + 2]; // [R4]
            end else if (k < nb) begin
                ain_map[k] = term_ana[k - 2]; // [R4]
            end else if (k - nb < NUM_EXP_AI) begin
                ain_map[k] = exp_ana[k - nb]; // [R6]
            end
        end
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        logic [6:0] need;
        logic mains_in;
        logic do_wr;
        logic [31:0] dv;
        logic [16:0] sum_b;
        logic [8:0] sum_r;
        logic [7:0] rem_chg;
        logic [5:0] ai;
        logic [63:0] vis_new;
        logic [31:0] rd;
        logic rd_ok;
        need = 7'h00;
        mains_in = 1'b0;
        dv = 32'h0000_0000;
        sum_b = 17'h0_0000;
        sum_r = 9'h000;
        rem_chg = 8'h00;
        ai = 6'h00;
        vis_new = st_ff.flag_vis;
        rd = 32'h0000_0000;
        rd_ok = 1'b1;
        nxt_st = st_ff;
        ram_we = 1'b0;
        ram_waddr = 7'h00;
        ram_wdata = st_ff.w_data[15:0];
        ram_raddr = {st_ff.af_sel[aflag_idx(axi_req.araddr)], aflag_idx(axi_req.araddr)};

        // millisecond timebase
        nxt_st.ms_tick = 1'b0;
        if (st_ff.ms_cnt == MS_W'(CYC_PER_MS - 1)) begin
            nxt_st.ms_cnt = '0;
            nxt_st.ms_tick = 1'b1;
        end else begin
            nxt_st.ms_cnt = st_ff.ms_cnt + 1'b1;
        end

        // input filters: the timebase gives about one ms of extra jitter per edge
        nxt_st.din_s = din_raw;
        for (int i = 0; i < NUM_DI; i++) begin
            mains_in = st_ff.ctrl[`PCF_CTRL_MAINS] && i < `PCF_MAINS_INPUTS;
            if (st_ff.ctrl[`PCF_CTRL_SLAVE]) begin
                need = st_ff.din_s[i] ? 7'(`PCF_T_SLAVE_ON_MS) :
                       7'(`PCF_T_SLAVE_HOLD_MS); // [R3]
            end else if (mains_in) begin
                need = st_ff.din_s[i] ? 7'(`PCF_T_ON_MAINS_MS) :
                       7'(`PCF_T_OFF_MAINS_MS); // [R1]
            end else begin
                need = 7'(`PCF_T_STD_MS); // [R2]
            end
            if (st_ff.din_s[i] == st_ff.din_acc[i]) begin
                nxt_st.flt_cnt[i] = 7'h00; // [R21]
            end else if (st_ff.flt_cnt[i] >= need) begin
                nxt_st.din_acc[i] = st_ff.din_s[i]; // [R21]
                nxt_st.flt_cnt[i] = 7'h00;
            end else if (st_ff.ms_tick) begin
                nxt_st.flt_cnt[i] = st_ff.flt_cnt[i] + 7'h01;
            end
        end

        nxt_st.keys = keys_base | keys_panel; // [R17]

        // backlight outputs follow the visible flags; charset follows its flag only when PCF_CTRL_CS_IN_PROG is set
        nxt_st.bl_base = '{white: st_ff.flag_vis[`PCF_FLAG_BASE_WHITE],
                           amber: st_ff.flag_vis[`PCF_FLAG_BASE_AMBER],
                           red: st_ff.flag_vis[`PCF_FLAG_BASE_RED]};
        nxt_st.bl_panel = '{white: st_ff.flag_vis[`PCF_FLAG_PANEL_WHITE],
                            amber: st_ff.flag_vis[`PCF_FLAG_PANEL_AMBER],
                            red: st_ff.flag_vis[`PCF_FLAG_PANEL_RED]};
        nxt_st.charset = st_ff.ctrl[`PCF_CTRL_CS_IN_PROG] ?
                         st_ff.flag_vis[`PCF_FLAG_CHARSET] :
                         st_ff.ctrl[`PCF_CTRL_CS_DEFAULT]; // [R14] [R15]

        // write channel: address and data taken in either order
        if (axi_req.awvalid && st_ff.awready) begin
            nxt_st.awready = 1'b0;
            nxt_st.aw_addr = axi_req.awaddr;
        end
        if (axi_req.wvalid && st_ff.wready) begin
            nxt_st.wready = 1'b0;
            nxt_st.w_data = axi_req.wdata;
            nxt_st.w_strb = axi_req.wstrb;
        end
        do_wr = !st_ff.awready && !st_ff.wready && !st_ff.bvalid;
        if (do_wr) begin
            nxt_st.bvalid = 1'b1;
            nxt_st.bresp = `PCF_RESP_OKAY;
            unique case (st_ff.aw_addr)
                `PCF_OFS_CTRL: begin
                    dv = wmerge(32'(st_ff.ctrl), st_ff.w_data, st_ff.w_strb);
                    nxt_st.ctrl = dv[4:0];
                end
                `PCF_OFS_CYCLE: begin
                    // end of program cycle: staged flags become visible
                    vis_new = st_ff.flag_nxt; // [R11]
                    vis_new[`PCF_FLAG_BASE_WHITE] = base_mode == MODE_RUN
                                                    && !base_diag_err; // [R13]
                    vis_new[`PCF_FLAG_BASE_AMBER] = (base_mode == MODE_PROG ||
                        base_mode == MODE_PARAM) && !base_diag_err; // [R13]
                    vis_new[`PCF_FLAG_BASE_RED] = base_diag_err; // [R13]
                    vis_new[`PCF_FLAG_PANEL_WHITE] = panel_mode == MODE_RUN
                                                     && !panel_diag_err; // [R13]
                    vis_new[`PCF_FLAG_PANEL_AMBER] = panel_mode != MODE_RUN
                                                     && !panel_diag_err; // [R13]
                    vis_new[`PCF_FLAG_PANEL_RED] = panel_diag_err; // [R13]
                    nxt_st.flag_vis = vis_new; // [R10] [R12]
                    nxt_st.first = 1'b0; // [R12]
                    nxt_st.af_sel = st_ff.af_sel ^ st_ff.af_dirty; // [R11]
                    nxt_st.af_valid = st_ff.af_valid | st_ff.af_dirty;
                    nxt_st.af_dirty = 64'h0000_0000_0000_0000;
                end
                `PCF_OFS_DQ: begin
                    dv = wmerge(32'(st_ff.dq), st_ff.w_data, st_ff.w_strb);
                    nxt_st.dq = dv[NUM_DQ-1:0]; // [R7]
                end
                `PCF_OFS_BLANK: begin
                    // sink only, nothing is stored to read back
                    nxt_st.bresp = `PCF_RESP_OKAY; // [R8]
                end
                `PCF_OFS_MEM_REQ: begin
                    rem_chg = st_ff.w_data[31] ? st_ff.w_data[23:16] : 8'h00; // [R20]
                    sum_b = 17'(st_ff.mem_bytes) + 17'(st_ff.w_data[15:0]); // [R20]
                    sum_r = 9'(st_ff.mem_rem) + 9'(rem_chg); // [R20]
                    if (sum_b <= 17'(MAX_BYTES) && st_ff.mem_blocks < 9'(MAX_BLOCKS) &&
                        sum_r <= 9'(MAX_REM)) begin // [R18]
                        nxt_st.mem_bytes = sum_b[13:0];
                        nxt_st.mem_blocks = st_ff.mem_blocks + 9'h001; // [R20]
                        nxt_st.mem_rem = sum_r[7:0];
                        nxt_st.mem_refused = 1'b0;
                    end else begin
                        nxt_st.mem_refused = 1'b1; // [R19]
                    end
                end
                `PCF_OFS_MEM_CLR: begin
                    nxt_st.mem_bytes = 14'h0000;
                    nxt_st.mem_blocks = 9'h000;
                    nxt_st.mem_rem = 8'h00;
                    nxt_st.mem_refused = 1'b0;
                end
                `PCF_OFS_DFLAG_LO: begin
                    nxt_st.flag_nxt[31:0] = wmerge(st_ff.flag_nxt[31:0], st_ff.w_data,
                                                   st_ff.w_strb); // [R10] [R15]
                end
                `PCF_OFS_DFLAG_HI: begin
                    nxt_st.flag_nxt[63:32] = wmerge(st_ff.flag_nxt[63:32], st_ff.w_data,
                                                    st_ff.w_strb); // [R10] [R15]
                end
                default: begin
                    if (st_ff.aw_addr[11:5] == `PCF_OFS_AQ >> 5) begin
                        dv = wmerge(32'(st_ff.aq[st_ff.aw_addr[4:2]]), st_ff.w_data,
                                    st_ff.w_strb);
                        nxt_st.aq[st_ff.aw_addr[4:2]] = dv[15:0]; // [R9]
                    end else if (is_aflag(st_ff.aw_addr)) begin
                        ai = aflag_idx(st_ff.aw_addr);
                        ram_we = 1'b1; // [R10]
                        ram_waddr = {!st_ff.af_sel[ai], ai}; // [R11]
                        nxt_st.af_dirty[ai] = 1'b1;
                    end else begin
                        // shift bits, inputs, keys and unmapped words refuse writes
                        nxt_st.bresp = `PCF_RESP_SLVERR; // [R16]
                    end
                end
            endcase
        end
        if (st_ff.bvalid && axi_req.bready) begin
            nxt_st.bvalid = 1'b0;
            nxt_st.awready = 1'b1;
            nxt_st.wready = 1'b1;
        end

        // read channel: two cycles so the flag store can answer
        unique case (st_ff.ar_addr)
            `PCF_OFS_CTRL: rd = 32'(st_ff.ctrl);
            `PCF_OFS_CYCLE: rd = 32'(st_ff.first);
            `PCF_OFS_DIN: rd = 32'(st_ff.din_acc); // [R7]
            `PCF_OFS_KEYS: rd = 32'(st_ff.keys); // [R17]
            `PCF_OFS_SHIFT: rd = shift_bits; // [R16]
            `PCF_OFS_DQ: rd = 32'(st_ff.dq);
            `PCF_OFS_BLANK: rd = 32'h0000_0000; // [R8]
            `PCF_OFS_MEM_REQ: rd = {30'h0000_0000, st_ff.mem_blocks >= 9'(MAX_BLOCKS) ||
                                    st_ff.mem_bytes >= 14'(MAX_BYTES), st_ff.mem_refused};
            `PCF_OFS_MEM_USED: rd = {7'h00, st_ff.mem_blocks, 2'h0, st_ff.mem_bytes};
            `PCF_OFS_MEM_REM: rd = 32'(st_ff.mem_rem);
            `PCF_OFS_DFLAG_LO: rd = st_ff.flag_vis[31:0]; // [R11]
            `PCF_OFS_DFLAG_HI: rd = st_ff.flag_vis[63:32]; // [R11]
            default: begin
                if (st_ff.ar_addr[11:5] == `PCF_OFS_AQ >> 5) begin
                    rd = 32'(st_ff.aq[st_ff.ar_addr[4:2]]);
                end else if (st_ff.ar_addr[11:5] == `PCF_OFS_AIN >> 5) begin
                    rd = 32'(ain_map[st_ff.ar_addr[4:2]]); // [R4] [R6]
                end else if (is_aflag(st_ff.ar_addr)) begin
                    rd = st_ff.af_valid[aflag_idx(st_ff.ar_addr)] ?
                         32'(ram_rdata) : 32'h0000_0000; // [R11]
                end else begin
                    rd_ok = 1'b0;
                end
            end
        endcase
        unique case (st_ff.rd_st)
            RD_IDLE: begin
                if (axi_req.arvalid) begin
                    nxt_st.arready = 1'b0;
                    nxt_st.ar_addr = axi_req.araddr;
                    nxt_st.rd_st = RD_WAIT;
                end
            end
            RD_WAIT: begin
                nxt_st.rdata = rd;
                nxt_st.rresp = rd_ok ? `PCF_RESP_OKAY : `PCF_RESP_SLVERR;
                nxt_st.rvalid = 1'b1;
                nxt_st.rd_st = RD_RESP;
            end
            RD_RESP: begin
                if (axi_req.rready) begin
                    nxt_st.rvalid = 1'b0;
                    nxt_st.arready = 1'b1;
                    nxt_st.rd_st = RD_IDLE;
                end
            end
            default: begin
                nxt_st.rd_st = RD_IDLE;
                nxt_st.arready = 1'b1;
                nxt_st.rvalid = 1'b0;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_ff <= '0;
            st_ff.ctrl <= `PCF_CTRL_RST;
            st_ff.flag_vis <= `PCF_FLAG_VIS_RST; // [R12]
            st_ff.first <= 1'b1; // [R12]
            st_ff.awready <= 1'b1;
            st_ff.wready <= 1'b1;
            st_ff.arready <= 1'b1;
            st_ff.rd_st <= RD_IDLE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    pcf_flag_ram #(
        .DW(16),
        .AW(7)
    ) u_flag_ram (
        .aclk(aclk),
        .we(ram_we),
        .waddr(ram_waddr),
        .wdata(ram_wdata),
        .raddr(ram_raddr),
        .rdata(ram_rdata)
    );

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign axi_rsp = '{awready: st_ff.awready, wready: st_ff.wready, bresp: st_ff.bresp,
                       bvalid: st_ff.bvalid, arready: st_ff.arready, rdata: st_ff.rdata,
                       rresp: st_ff.rresp, rvalid: st_ff.rvalid};
    assign din_filt = st_ff.din_acc;
    assign dq_out = st_ff.dq;
    assign aq_out = st_ff.aq;
    assign flag_out = st_ff.flag_vis;
    assign base_backlight = st_ff.bl_base;
    assign panel_backlight = st_ff.bl_panel;
    assign charset_sel = st_ff.charset;
    assign first_cycle = st_ff.first;
endmodule

// ---- rtl/pcf_defines.svh ----
// register map, field positions, reset values and timing constants of the plc connector block
`ifndef PCF_DEFINES_SVH
`define PCF_DEFINES_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define PCF_ADDR_W 12
`define PCF_OFS_CTRL 12'h000
`define PCF_OFS_CYCLE 12'h004
`define PCF_OFS_DIN 12'h008
`define PCF_OFS_KEYS 12'h00C
`define PCF_OFS_SHIFT 12'h010
`define PCF_OFS_DQ 12'h014
`define PCF_OFS_BLANK 12'h018
`define PCF_OFS_MEM_REQ 12'h01C
`define PCF_OFS_MEM_USED 12'h020
`define PCF_OFS_MEM_REM 12'h024
`define PCF_OFS_MEM_CLR 12'h028
`define PCF_OFS_DFLAG_LO 12'h030
`define PCF_OFS_DFLAG_HI 12'h034
`define PCF_OFS_AQ 12'h040
`define PCF_OFS_AIN 12'h060
`define PCF_OFS_AFLAG 12'h100

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define PCF_CTRL_MAINS 0
`define PCF_CTRL_SLAVE 1
`define PCF_CTRL_FOUR_AI 2
`define PCF_CTRL_CS_IN_PROG 3
`define PCF_CTRL_CS_DEFAULT 4
`define PCF_CTRL_RST 5'h04
`define PCF_FLAG_STARTUP 7
`define PCF_FLAG_BASE_WHITE 24
`define PCF_FLAG_PANEL_WHITE 25
`define PCF_FLAG_CHARSET 26
`define PCF_FLAG_BASE_AMBER 27
`define PCF_FLAG_BASE_RED 28
`define PCF_FLAG_PANEL_AMBER 29
`define PCF_FLAG_PANEL_RED 30
`define PCF_FLAG_VIS_RST 64'h0000_0000_0000_0080
`define PCF_MAINS_INPUTS 8
`define PCF_RESP_OKAY 2'h0
`define PCF_RESP_SLVERR 2'h2

// ----------------------------------------------------------------
// timing and budget
// ----------------------------------------------------------------
`define PCF_CLK_HZ 100000000
`define PCF_TIMEBASE_MS 1
`define PCF_CYC_PER_MS (`PCF_CLK_HZ / 1000 * `PCF_TIMEBASE_MS)
`define PCF_T_ON_MAINS_MS 25
`define PCF_T_OFF_MAINS_MS 20
`define PCF_T_STD_MS 5
`define PCF_T_SLAVE_ON_MS 5
`define PCF_T_SLAVE_HOLD_MS 100
`define PCF_MAX_BYTES 8500
`define PCF_MAX_BLOCKS 400
`define PCF_MAX_REM 250

`endif

// ---- rtl/pcf_pkg.sv ----
// types shared by the plc connector block and its bus
package pcf_pkg;

    typedef struct packed {
        logic [11:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [11:0] araddr;
        logic arvalid;
        logic rready;
    } pcf_axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic [1:0] bresp;
        logic bvalid;
        logic arready;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic rvalid;
    } pcf_axi_rsp_t;

    typedef enum logic [1:0] {
        RD_IDLE = 2'h0,
        RD_WAIT = 2'h1,
        RD_RESP = 2'h3
    } pcf_rd_st_t;

    typedef enum logic [1:0] {
        MODE_RUN = 2'h0,
        MODE_PROG = 2'h1,
        MODE_PARAM = 2'h3,
        MODE_SETUP = 2'h2
    } pcf_mode_t;

    typedef struct packed {
        logic white;
        logic amber;
        logic red;
    } pcf_backlight_t;

endpackage

// ---- rtl/pcf_flag_ram.sv ----
// two-bank word store for the analog flags, registered read port
`timescale 1ns/1ns
module pcf_flag_ram #(
    parameter int DW = 16,
    parameter int AW = 7
) (
    input logic aclk,
    input logic we,
    input logic [AW-1:0] waddr,
    input logic [DW-1:0] wdata,
    input logic [AW-1:0] raddr,
    output logic [DW-1:0] rdata
);
    logic [DW-1:0] mem_ff [2**AW];
    logic [DW-1:0] rdata_ff;

    initial begin
        if (DW < 1 || AW < 1) begin
            $error("pcf_flag_ram: bad geometry");
        end
    end

    // no reset on the array: contents are qualified by a valid vector upstream
    always_ff @(posedge aclk) begin
        if (we) begin
            mem_ff[waddr] <= wdata;
        end
        rdata_ff <= mem_ff[raddr];
    end

    assign rdata = rdata_ff;
endmodule

// ---- bench/pcf_field_model.sv ----
// field switch model: commanded levels, optional contact chatter
`timescale 1ns/1ns
module pcf_field_model (
    input logic aclk,
    input logic [23:0] lvl,
    input logic [23:0] chat,
    output logic [23:0] din_raw
);
    logic ph = 1'b0;
    // a bouncing contact flips every cycle so no filter count can build up
    always @(posedge aclk) ph <= ~ph;
    assign din_raw = lvl ^ (chat & {24{ph}});
endmodule

// ---- bench/pcf_io_chk.sv ----
// port assertions of the plc connector block
`timescale 1ns/1ns
module pcf_io_chk import pcf_pkg::*; #(
    parameter int NUM_DI = 24
) (
    input logic aclk,
    input logic aresetn,
    input pcf_pkg::pcf_axi_req_t axi_req,
    input pcf_pkg::pcf_axi_rsp_t axi_rsp,
    input logic [NUM_DI-1:0] din_raw,
    input logic [NUM_DI-1:0] din_filt,
    input logic [63:0] flag_out,
    input pcf_pkg::pcf_backlight_t base_backlight,
    input logic first_cycle
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_filt_rise: assert property ($rose(din_filt[8]) |-> $past(din_raw[8], 3)) else $error("early rise");
    a_filt_fall: assert property ($fell(din_filt[8]) |-> !$past(din_raw[8], 3)) else $error("early fall");
    a_rd_answer: assert property (axi_req.arvalid && axi_rsp.arready |-> ##[1:3] axi_rsp.rvalid) else $error("late read");
    a_wr_answer: assert property (axi_req.awvalid && axi_rsp.awready && axi_req.wvalid |-> ##[1:3] axi_rsp.bvalid) else $error("late write");
    a_flag_still: assert property (!$stable(flag_out) |-> axi_rsp.bvalid || $past(axi_rsp.bvalid)) else $error("flag moved");
    a_start_high: assert property (first_cycle |-> flag_out[7]) else $error("startup low");
    a_fresh_start: assert property ($rose(aresetn) |-> first_cycle && flag_out == 64'h0000_0000_0000_0080) else $error("bad start");
    a_light_copy: assert property (base_backlight == {$past(flag_out[24]), $past(flag_out[27]), $past(flag_out[28])}) else $error("backlight");
    c_filt: cover property ($rose(din_filt[8]));
    c_first: cover property ($fell(first_cycle));
    c_amber: cover property (base_backlight.amber);
endmodule
bind pcf_io_top pcf_io_chk #(.NUM_DI(NUM_DI)) u_chk (.aclk(aclk), .aresetn(aresetn), .axi_req(axi_req),
    .axi_rsp(axi_rsp), .din_raw(din_raw), .din_filt(din_filt), .flag_out(flag_out),
    .base_backlight(base_backlight), .first_cycle(first_cycle));

// ---- bench/tb_plc_io_connectors_and_flags.sv ----
// self-checking bench of the plc connector block
`timescale 1ns/1ns
`include "pcf_defines.svh"
module tb_plc_io_connectors_and_flags;
    import pcf_pkg::*;
    logic aclk = 1'b0, aresetn = 1'b0, fc, bed, ped;
    pcf_axi_req_t rq = '0;
    pcf_axi_rsp_t rs;
    logic [23:0] lvl = '0, chat = '0, raw, filt;
    logic [3:0][15:0] ta, ea;
    logic [3:0] kb = 4'h1, kp = 4'h4;
    logic [31:0] sb, rdv;
    logic [1:0] rsp;
    pcf_mode_t bm = MODE_RUN, pm = MODE_RUN;
    pcf_backlight_t bbl, pbl;
    int bad_count = 0, checked = 0, cyc = 0, ub = 0;
    pcf_field_model u_fld (.aclk(aclk), .lvl(lvl), .chat(chat), .din_raw(raw));
    pcf_io_top #(.CYC_PER_MS(10)) dut (.aclk(aclk), .aresetn(aresetn), .axi_req(rq), .axi_rsp(rs),
        .din_raw(raw), .term_ana(ta), .exp_ana(ea), .keys_base(kb), .keys_panel(kp), .shift_bits(sb),
        .base_mode(bm), .panel_mode(pm), .base_diag_err(bed), .panel_diag_err(ped), .din_filt(filt),
        .dq_out(), .aq_out(), .flag_out(), .base_backlight(bbl), .panel_backlight(pbl),
        .charset_sel(), .first_cycle(fc));
    // ---
    // bus access and comparison
    // ---
    task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        logic [3:0] hs;
        @(posedge aclk);
        rq <= {a, w, d, 4'hf, w, 1'b1, a, !w, 1'b1};
        // settled values seen mid-cycle are what the next rising edge samples
        do begin
            @(negedge aclk);
            hs = {rs.bvalid || rs.rvalid, rs.awready, rs.wready, rs.arready};
            rsp = rs.bvalid ? rs.bresp : rs.rresp;
            rdv = rs.rdata;
            @(posedge aclk);
            {rq.awvalid, rq.wvalid, rq.arvalid} <= {rq.awvalid, rq.wvalid, rq.arvalid} & ~hs[2:0];
        end while (!hs[3]);
        rq.bready <= 1'b0;
        rq.rready <= 1'b0;
    endtask
    task chk(input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            bad_count++;
            $display("wrong value at %0t: got %h want %h", $time, s, e);
        end
    endtask
    task wrap_up;
        $display("comparisons %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // ---
    // clock, timeout, tests
    // ---
    initial forever #5 aclk = ~aclk;
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc > 6000) begin
            bad_count++;
            wrap_up;
        end
    end
    initial begin
        void'($urandom(32'h5edf));
        {ta, ea, sb, bed, ped} = {$urandom, $urandom, $urandom, $urandom, $urandom, 2'b00};
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        bus(0, `PCF_OFS_SHIFT, 0); chk(rdv, sb);
        bus(1, `PCF_OFS_SHIFT, 1); chk(rsp, 2);
        bus(0, `PCF_OFS_KEYS, 0); chk(rdv, 5);
        bus(0, `PCF_OFS_AIN, 0); chk(rdv, ta[2]);
        bus(0, `PCF_OFS_AIN + 8, 0); chk(rdv, ta[0]);
        $display("end of port reads");
        bus(1, `PCF_OFS_DFLAG_LO, 1); bus(0, `PCF_OFS_DFLAG_LO, 0); chk(rdv, 32'h0000_0080);
        bm <= MODE_PROG;
        bus(1, `PCF_OFS_CYCLE, 0); bus(0, `PCF_OFS_DFLAG_LO, 0); chk(rdv, 32'h0a00_0001);
        chk({fc, bbl, pbl}, 7'h14);
        $display("end of flag cycle");
        chat[8] <= 1'b1; repeat (40) @(posedge aclk); chat[8] <= 1'b0; lvl[8] <= 1'b1;
        repeat (30) @(posedge aclk); bus(0, `PCF_OFS_DIN, 0); chk(rdv[8], 0);
        repeat (40) @(posedge aclk); bus(0, `PCF_OFS_DIN, 0); chk(rdv[8], 1);
        bus(1, `PCF_OFS_CTRL, 1); lvl[0] <= 1'b1; lvl[8] <= 1'b0;
        bus(0, `PCF_OFS_AIN + 8, 0); chk(rdv, ea[0]);
        repeat (220) @(posedge aclk); bus(0, `PCF_OFS_DIN, 0); chk(rdv[0], 0);
        repeat (60) @(posedge aclk); bus(0, `PCF_OFS_DIN, 0); chk(rdv[0], 1);
        lvl[0] <= 1'b0; repeat (170) @(posedge aclk); bus(0, `PCF_OFS_DIN, 0); chk(rdv[0], 1);
        repeat (60) @(posedge aclk); bus(0, `PCF_OFS_DIN, 0); chk(rdv[0], 0);
        bus(1, `PCF_OFS_CTRL, 2); lvl[9] <= 1'b1; repeat (80) @(posedge aclk); lvl[9] <= 1'b0;
        repeat (300) @(posedge aclk); bus(0, `PCF_OFS_DIN, 0); chk(rdv[9], 1);
        $display("end of input filters");
        ub = 8500; bus(1, `PCF_OFS_MEM_REQ, ub); bus(1, `PCF_OFS_MEM_REQ, 1);
        bus(0, `PCF_OFS_MEM_REQ, 0); chk(rdv[0], 1);
        bus(0, `PCF_OFS_MEM_USED, 0); chk(rdv, (1 << 16) | ub);
        $display("end of budget");
        wrap_up;
    end
endmodule
